// ---- src/programmable_io_cell.v ----
// one bank of programmable io cells between core fabric and pad buffers
// assumes all inputs synchronous to clk_sys_in; pad pins are split into
// input, output and output enable; the bench resolves the wire level
//
// Functional notes
// - each cell has input, output and tri-state paths plus a freeze latch.
// - one bank-wide freeze control acts on unregistered inputs only.
// - while frozen an unregistered input shows the last pad value taken.
// - an input is captured on the input register clock or passed through.
// - output data is captured on the output register clock or passed out.
// - input and output registers have own clocks and share a clock enable.
// - mode selects come from the configuration image and lock once loaded.
// - unconfigured pads float with pull-up on until the download is done and supplies are good.
// - core-facing outputs stay quiet until the power-on reset is released.
// - user pin settings apply only after reset release and a full download.
// - once configured an unused pin has its input blocked and pull-up off.
// - each pin selects weak pull-up or no bus maintenance on its own.
// - registered inputs freeze by a held clock or enable, not by the latch.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "io_cell_regs.vh"

module programmable_io_cell #(
    parameter NUM_CELLS = 8
) (
    // clock, reset, global clock enable
    input  wire                 clk_sys_in,
    input  wire                 rst_n_in,
    input  wire                 clk_en_in,
    // ahb-lite slave
    input  wire                 hsel_in,
    input  wire [31:0]          haddr_in,
    input  wire [1:0]           htrans_in,
    input  wire                 hwrite_in,
    input  wire [2:0]           hsize_in,
    input  wire [31:0]          hwdata_in,
    input  wire                 hready_in,
    output reg  [31:0]          hrdata_out,
    output reg                  hreadyout_out,
    output reg                  hresp_out,
    // supply monitor
    input  wire                 supply_ok_in,
    // core side
    input  wire [NUM_CELLS-1:0] core_dout_in,
    input  wire [NUM_CELLS-1:0] core_oe_in,
    input  wire                 in_clk_in,
    input  wire                 out_clk_in,
    input  wire                 io_ce_in,
    input  wire                 freeze_in,
    output reg  [NUM_CELLS-1:0] core_din_out,
    // pad side
    input  wire [NUM_CELLS-1:0] pad_in_in,
    output reg  [NUM_CELLS-1:0] pad_out_out,
    output reg  [NUM_CELLS-1:0] pad_oe_out,
    output reg  [NUM_CELLS-1:0] pad_pullup_out,
    output reg  [NUM_CELLS-1:0] pad_in_en_out
);

    // configuration image
    reg  [NUM_CELLS-1:0] used_reg;
    reg  [NUM_CELLS-1:0] in_reg_en_reg;
    reg  [NUM_CELLS-1:0] out_reg_en_reg;
    reg  [NUM_CELLS-1:0] oe_reg_en_reg;
    reg  [NUM_CELLS-1:0] pull_en_reg;
    reg                  cfg_done_reg;
    reg                  active_reg;

    // bus data phase
    reg                  wr_pend_reg;
    reg  [`ADDR_W-1:0]   wr_addr_reg;
    reg  [31:0]          rd_word;

    // cell path state
    reg                  in_clk_prev_reg;
    reg                  out_clk_prev_reg;
    reg  [NUM_CELLS-1:0] in_q_reg;
    reg  [NUM_CELLS-1:0] hold_reg;
    reg  [NUM_CELLS-1:0] out_q_reg;
    reg  [NUM_CELLS-1:0] oe_q_reg;

    // chosen routes of the three cell paths
    wire [NUM_CELLS-1:0] din_direct;
    wire [NUM_CELLS-1:0] din_sel;
    wire [NUM_CELLS-1:0] out_sel;
    wire [NUM_CELLS-1:0] oe_sel;

    // combinational next values
    reg  [NUM_CELLS-1:0] core_din_next;
    reg  [NUM_CELLS-1:0] pad_out_next;
    reg  [NUM_CELLS-1:0] pad_oe_next;
    reg  [NUM_CELLS-1:0] pad_pullup_next;
    reg  [NUM_CELLS-1:0] pad_in_en_next;

    wire addr_phase;
    wire in_rise;
    wire out_rise;
    wire cfg_write;

    // a transfer is taken only when the previous one has completed
    assign addr_phase = hsel_in & htrans_in[`HTRANS_SEQ_BIT] & hready_in;

    // the register clocks are sampled, so a rising level is the edge
    assign in_rise  = in_clk_in & ~in_clk_prev_reg;
    assign out_rise = out_clk_in & ~out_clk_prev_reg;

    // image writes land only while the download is still open
    assign cfg_write = wr_pend_reg & ~cfg_done_reg;

    // read mux, looked up in the address phase
    always @* begin
        rd_word = 32'h0000_0000;
        case (haddr_in[`ADDR_W-1:0])
            `CTRL_OFS: begin
                rd_word[`CTRL_DONE_BIT] = cfg_done_reg;
            end
            `USED_OFS: begin
                rd_word[NUM_CELLS-1:0] = used_reg;
            end
            `IN_REG_OFS: begin
                rd_word[NUM_CELLS-1:0] = in_reg_en_reg;
            end
            `OUT_REG_OFS: begin
                rd_word[NUM_CELLS-1:0] = out_reg_en_reg;
            end
            `OE_REG_OFS: begin
                rd_word[NUM_CELLS-1:0] = oe_reg_en_reg;
            end
            `PULL_OFS: begin
                rd_word[NUM_CELLS-1:0] = pull_en_reg;
            end
            `STATUS_OFS: begin
                rd_word[`STAT_ACTIVE_BIT] = active_reg;
                rd_word[`STAT_SUPPLY_BIT] = supply_ok_in;
                rd_word[`STAT_FREEZE_BIT] = freeze_in;
                rd_word[`STAT_DONE_BIT]   = cfg_done_reg;
            end
            `PAD_IN_OFS: begin
                rd_word[NUM_CELLS-1:0] = pad_in_in;
            end
            `CORE_IN_OFS: begin
                rd_word[NUM_CELLS-1:0] = core_din_out;
            end
            default: begin
                rd_word = 32'h0000_0000;                 // unmapped reads 0
            end
        endcase
    end

    // bus slave: zero wait states, always okay
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= {`ADDR_W{1'b0}};
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= `HREADY_RST;
            hresp_out     <= `HRESP_OKAY;
        end else if (clk_en_in) begin
            wr_pend_reg   <= addr_phase & hwrite_in;
            hreadyout_out <= 1'b1;
            hresp_out     <= `HRESP_OKAY;
            if (addr_phase) begin
                wr_addr_reg <= haddr_in[`ADDR_W-1:0];
                if (!hwrite_in) begin
                    hrdata_out <= rd_word;
                end
            end
        end
    end

    // configuration image; the download closes by setting the done bit
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            used_reg       <= {NUM_CELLS{`CFG_RST_BIT}};
            in_reg_en_reg  <= {NUM_CELLS{`CFG_RST_BIT}};
            out_reg_en_reg <= {NUM_CELLS{`CFG_RST_BIT}};
            oe_reg_en_reg  <= {NUM_CELLS{`CFG_RST_BIT}};
            pull_en_reg    <= {NUM_CELLS{`PULL_RST_BIT}};
            cfg_done_reg   <= `DONE_RST;
        end else if (clk_en_in && cfg_write) begin
            // static mode selects; the core has no path into them
            case (wr_addr_reg)
                `CTRL_OFS: begin
                    cfg_done_reg <= hwdata_in[`CTRL_DONE_BIT];
                end
                `USED_OFS: begin
                    used_reg <= hwdata_in[NUM_CELLS-1:0];
                end
                `IN_REG_OFS: begin
                    in_reg_en_reg <= hwdata_in[NUM_CELLS-1:0];
                end
                `OUT_REG_OFS: begin
                    out_reg_en_reg <= hwdata_in[NUM_CELLS-1:0];
                end
                `OE_REG_OFS: begin
                    oe_reg_en_reg <= hwdata_in[NUM_CELLS-1:0];
                end
                `PULL_OFS: begin
                    pull_en_reg <= hwdata_in[NUM_CELLS-1:0];
                end
                default: begin
                    cfg_done_reg <= cfg_done_reg;   // read-only or unmapped
                end
            endcase
        end
    end

    // user settings need both a finished download and good supplies
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active_reg <= 1'b0;
        end else if (clk_en_in) begin
            active_reg <= cfg_done_reg & supply_ok_in;
        end
    end

    // edge history of the two register clocks
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            in_clk_prev_reg  <= 1'b0;
            out_clk_prev_reg <= 1'b0;
        end else if (clk_en_in) begin
            in_clk_prev_reg  <= in_clk_in;
            out_clk_prev_reg <= out_clk_in;
        end
    end

    // input register path: own clock, shared enable
    // holding either one is what freezes a registered input
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            in_q_reg <= {NUM_CELLS{1'b0}};
        end else if (clk_en_in && in_rise && io_ce_in) begin
            in_q_reg <= pad_in_in;
        end
    end

    // freeze latch: one bank-wide control, follows the pad while open
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_reg <= {NUM_CELLS{1'b0}};
        end else if (clk_en_in && !freeze_in) begin
            hold_reg <= pad_in_in;
        end
    end

    // output and tri-state register paths share the output clock
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_q_reg <= {NUM_CELLS{1'b0}};
            oe_q_reg  <= {NUM_CELLS{1'b0}};
        end else if (clk_en_in && out_rise && io_ce_in) begin
            out_q_reg <= core_dout_in;
            oe_q_reg  <= core_oe_in;
        end
    end

    // unregistered inputs take the held value while the bank is frozen
    assign din_direct = freeze_in ? hold_reg : pad_in_in;

    // registered inputs ignore the freeze; the latch serves the rest
    io_path_mux #(
        .WIDTH         (NUM_CELLS)
    ) u_din_route (
        .reg_sel_in    (in_reg_en_reg),
        .reg_val_in    (in_q_reg),
        .direct_val_in (din_direct),
        .route_out     (din_sel)
    );

    // output data: the captured copy or the live core value
    io_path_mux #(
        .WIDTH         (NUM_CELLS)
    ) u_out_route (
        .reg_sel_in    (out_reg_en_reg),
        .reg_val_in    (out_q_reg),
        .direct_val_in (core_dout_in),
        .route_out     (out_sel)
    );

    // output enable: same choice with its own select bits, so a pad can
    // be registered on data and direct on enable
    io_path_mux #(
        .WIDTH         (NUM_CELLS)
    ) u_oe_route (
        .reg_sel_in    (oe_reg_en_reg),
        .reg_val_in    (oe_q_reg),
        .direct_val_in (core_oe_in),
        .route_out     (oe_sel)
    );

    // per-cell pad state from the chosen routes
    always @* begin
        if (active_reg) begin
            // unused cells: input blocked, no drive, no pull-up
            core_din_next   = din_sel & used_reg;
            pad_oe_next     = oe_sel & used_reg;
            pad_out_next    = out_sel & pad_oe_next;
            pad_pullup_next = pull_en_reg & used_reg;
            pad_in_en_next  = used_reg;
        end else begin
            // pre-configuration: undriven, weak pull-up, core sees 0
            core_din_next   = {NUM_CELLS{1'b0}};
            pad_oe_next     = {NUM_CELLS{1'b0}};
            pad_out_next    = {NUM_CELLS{1'b0}};
            pad_pullup_next = {NUM_CELLS{1'b1}};
            pad_in_en_next  = {NUM_CELLS{1'b0}};
        end
    end

    // output flops; costs one cycle on the pass-through paths
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_din_out   <= {NUM_CELLS{1'b0}};
            pad_out_out    <= {NUM_CELLS{1'b0}};
            pad_oe_out     <= {NUM_CELLS{1'b0}};
            pad_pullup_out <= {NUM_CELLS{1'b1}};
            pad_in_en_out  <= {NUM_CELLS{1'b0}};
        end else if (clk_en_in) begin
            core_din_out   <= core_din_next;
            pad_out_out    <= pad_out_next;
            pad_oe_out     <= pad_oe_next;
            pad_pullup_out <= pad_pullup_next;
            pad_in_en_out  <= pad_in_en_next;
        end
    end

endmodule // programmable_io_cell

// one route choice per cell: the captured value where the static image
// selects the register, the direct value otherwise
module io_path_mux #(
    parameter WIDTH = 8
) (
    // static route select, one bit per cell
    input  wire [WIDTH-1:0] reg_sel_in,
    // captured and direct candidates
    input  wire [WIDTH-1:0] reg_val_in,
    input  wire [WIDTH-1:0] direct_val_in,
    // chosen value
    output wire [WIDTH-1:0] route_out
);

    // plain and-or select; cells never interact
    assign route_out = (reg_sel_in & reg_val_in)
                     | (~reg_sel_in & direct_val_in);

endmodule // io_path_mux

// ---- inc/io_cell_regs.vh ----
// register map, field positions and reset values of the io cell bank
// assumes a 32-bit bus slave that decodes the low address byte only
`ifndef IO_CELL_REGS_VH
`define IO_CELL_REGS_VH

// decoded address width
`define ADDR_W          8

// register byte offsets
`define CTRL_OFS        8'h00
`define USED_OFS        8'h04
`define IN_REG_OFS      8'h08
`define OUT_REG_OFS     8'h0c
`define OE_REG_OFS      8'h10
`define PULL_OFS        8'h14
`define STATUS_OFS      8'h18
`define PAD_IN_OFS      8'h1c
`define CORE_IN_OFS     8'h20

// control register fields
`define CTRL_DONE_BIT   0

// status register fields
`define STAT_ACTIVE_BIT 0
`define STAT_SUPPLY_BIT 1
`define STAT_FREEZE_BIT 2
`define STAT_DONE_BIT   3

// reset values, one bit per cell except the single done bit
`define CFG_RST_BIT     1'b0
`define PULL_RST_BIT    1'b1
`define DONE_RST        1'b0

// bus encodings
`define HTRANS_SEQ_BIT  1
`define HRESP_OKAY      1'b0
`define HREADY_RST      1'b1

`endif

// ---- test/programmable_io_cell_assertions.sv ----
// port checks of the io cell bank, bound into every instance
// assumes one clock; bus writes only while hsel_in is high
`timescale 1ns/1ps
module io_cell_checker #(parameter NUM_CELLS = 8) (
    // clock and reset
    input wire                 clk_sys_in,
    input wire                 rst_n_in,
    // supply and core controls
    input wire                 supply_ok_in,
    input wire                 freeze_in,
    input wire                 io_ce_in,
    input wire                 hsel_in,
    // cell outputs
    input wire [NUM_CELLS-1:0] core_din_out,
    input wire [NUM_CELLS-1:0] pad_out_out,
    input wire [NUM_CELLS-1:0] pad_oe_out,
    input wire [NUM_CELLS-1:0] pad_pullup_out,
    input wire [NUM_CELLS-1:0] pad_in_en_out
);
    reg up_reg;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // low only at the first edge after reset release
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) up_reg <= 1'b0;
        else up_reg <= 1'b1;
    end
    AST_RST_QUIET: assert property (!up_reg |->
        core_din_out == 0 && pad_oe_out == 0)
        else $error("outputs active at reset release");
    AST_PRECFG: assert property (!supply_ok_in [*2] |=>
        pad_oe_out == 0 && &pad_pullup_out)
        else $error("pins not released with supplies invalid");
    AST_NO_CORE: assert property (!supply_ok_in [*2] |=>
        core_din_out == 0 && pad_in_en_out == 0)
        else $error("inputs open with supplies invalid");
    AST_IN_EN_SUP: assert property (pad_in_en_out != 0 |->
        $past(supply_ok_in, 2))
        else $error("input opened before supplies valid");
    AST_OE_SUP: assert property ($rose(|pad_oe_out) |->
        $past(supply_ok_in, 2))
        else $error("pad driven before supplies valid");
    AST_OUT_GATED: assert property (
        (pad_out_out & ~pad_oe_out) == 0)
        else $error("data on an undriven pad");
    AST_UNUSED: assert property (
        (~pad_in_en_out & ~pad_pullup_out & (pad_oe_out | core_din_out)) == 0)
        else $error("unused cell not quiet");
    AST_FREEZE: assert property ((supply_ok_in && !hsel_in) [*2] ##1
        (freeze_in && !io_ce_in && supply_ok_in && !hsel_in) [*2]
        |=> $stable(core_din_out)) else $error("frozen input moved");
    AST_PULL_LOCK: assert property ((supply_ok_in && !hsel_in) [*4]
        |=> $stable(pad_pullup_out)) else $error("pull-up changed alone");
    cover property (freeze_in && !io_ce_in && supply_ok_in);
    cover property ($fell(supply_ok_in));
    cover property (pad_oe_out != 0 && pad_in_en_out != 0);
endmodule // io_cell_checker

bind programmable_io_cell io_cell_checker #(.NUM_CELLS(NUM_CELLS)) u_chk (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .supply_ok_in(supply_ok_in), .freeze_in(freeze_in),
    .io_ce_in(io_ce_in), .hsel_in(hsel_in), .core_din_out(core_din_out),
    .pad_out_out(pad_out_out), .pad_oe_out(pad_oe_out),
    .pad_pullup_out(pad_pullup_out), .pad_in_en_out(pad_in_en_out));

// ---- test/io_pad_model.sv ----
// pad wires of the bank: cell drive, else pull-up, else floating
// assumes the bench clock; a floating wire toggles every cycle
`timescale 1ns/1ps
module io_pad_model #(parameter N = 8) (
    // clock
    input  wire         clk_in,
    // cell side
    input  wire [N-1:0] pad_out_in,
    input  wire [N-1:0] pad_oe_in,
    input  wire [N-1:0] pull_in,
    // pad level seen by the cell
    output wire [N-1:0] level_out
);
    reg [N-1:0] float_reg = {N{1'b0}};
    // a stale level on a floating pad must never pass for data
    always @(posedge clk_in) float_reg <= ~float_reg;
    // drive wins, the weak pull-up only lifts an undriven pad
    assign level_out = (pad_oe_in & pad_out_in)
        | (~pad_oe_in & (pull_in | float_reg));
endmodule // io_pad_model

// ---- test/test_programmable_io_cell.sv ----
// self-checking bench of the io cell bank against a cell model
// assumes the pad model on the pins; bus waits follow hready
`timescale 1ns/1ps
`include "io_cell_regs.vh"
module test_programmable_io_cell;
    localparam N = 8;
    localparam [7:0] USED = 8'h7f, INR = 8'h0f, OUTR = 8'h33, OER = 8'h55;
    reg          clk, rst_n, hsel, hwrite, supply, in_clk, out_clk;
    reg          io_ce, freeze, chk_en, pin_clk, pout_clk, clk_en;
    reg  [1:0]   htrans;
    reg  [31:0]  haddr, hwdata, q;
    reg  [N-1:0] dout, oe, pull_m, hold_m, inreg_m, oreg_m, oereg_m;
    reg  [N-1:0] e_din, e_out, e_oe, s_din, s_out, s_oe;
    wire [N-1:0] lvl, din, pout, poe, pull, inen;
    wire [31:0]  hrdata;
    wire         hready, hresp;
    integer      err_count, checked, i;

    programmable_io_cell #(.NUM_CELLS(N)) dut (
        .clk_sys_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .supply_ok_in(supply), .core_dout_in(dout),
        .core_oe_in(oe), .in_clk_in(in_clk), .out_clk_in(out_clk),
        .io_ce_in(io_ce), .freeze_in(freeze), .core_din_out(din),
        .pad_in_in(lvl), .pad_out_out(pout), .pad_oe_out(poe),
        .pad_pullup_out(pull), .pad_in_en_out(inen));
    io_pad_model #(.N(N)) pads (.clk_in(clk), .pad_out_in(pout),
        .pad_oe_in(poe), .pull_in(pull), .level_out(lvl));

    task automatic cmp(input string what, input [31:0] exp, got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("mismatch %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // one single transfer; the answer edge decides, never a fixed count
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
            @(posedge clk);
            while (!hready) @(posedge clk);
            {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
            @(posedge clk);
            while (!hready) @(posedge clk);
            q = hrdata;
            cmp("hresp", 32'h0, {31'h0, hresp});
        end
    endtask
    task end_of_test;
        begin
            if (err_count == 0 && checked > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // cell model: compares last edge's expectation, then steps one edge
    always @(posedge clk) begin
        if (chk_en) begin
            cmp("core_din", e_din, din);
            cmp("pad_out", e_out, pout);
            cmp("pad_oe", e_oe, poe);
            cmp("pullup", USED & pull_m, pull);
            cmp("in_en", USED, inen);
        end
        hold_m = freeze ? hold_m : lvl;
        e_din = USED & ((INR & inreg_m) | (~INR & hold_m));
        if (in_clk && !pin_clk && io_ce) inreg_m = lvl;
        e_oe = USED & ((OER & oereg_m) | (~OER & oe));
        e_out = e_oe & ((OUTR & oreg_m) | (~OUTR & dout));
        if (out_clk && !pout_clk && io_ce) {oreg_m, oereg_m} = {dout, oe};
        {pin_clk, pout_clk} = {in_clk, out_clk};
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // watchdog well beyond the roughly 1550 cycles of the run
    initial begin
        repeat (6000) @(posedge clk);
        err_count = err_count + 1;
        end_of_test;
    end
    initial begin
        {rst_n, hsel, hwrite, supply, in_clk, out_clk, io_ce} = 7'h0;
        {freeze, chk_en, pin_clk, pout_clk, htrans} = 6'h0;
        {haddr, hwdata, dout, oe, hold_m, inreg_m, oreg_m, oereg_m} = 112'h0;
        {err_count, checked} = 64'h0;
        clk_en = 1'b1;
        q = $urandom(32'hfc8c);
        pull_m = q[N-1:0];
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        cmp("pre_oe", 8'h00, poe);
        cmp("pre_pull", 8'hff, pull);
        bus(1'b1, `USED_OFS, {24'h0, USED});
        bus(1'b1, `IN_REG_OFS, {24'h0, INR});
        bus(1'b1, `OUT_REG_OFS, {24'h0, OUTR});
        bus(1'b1, `OE_REG_OFS, {24'h0, OER});
        bus(1'b1, `PULL_OFS, {24'h0, pull_m});
        bus(1'b1, `CTRL_OFS, 32'h1);
        bus(1'b0, `PULL_OFS, 32'h0);
        cmp("pull_reg", {24'h0, pull_m}, q);
        repeat (3) @(posedge clk);
        // image loaded, supplies still invalid: pins stay released
        cmp("wait_oe", 8'h00, poe);
        cmp("wait_pull", 8'hff, pull);
        supply <= 1'b1;
        bus(1'b1, `USED_OFS, 32'h0);
        bus(1'b0, `USED_OFS, 32'h0);
        cmp("used_lock", {24'h0, USED}, q);
        bus(1'b0, `STATUS_OFS, 32'h0);
        cmp("status", 32'hb, q);
        bus(1'b0, 8'h40, 32'h0);
        cmp("unmapped", 32'h0, q);
        chk_en <= 1'b1;
        for (i = 0; i < 1500; i = i + 1) begin
            q = $urandom;
            {dout, oe} <= q[15:0];
            {in_clk, out_clk, io_ce, freeze} <= q[19:16];
            @(posedge clk);
        end
        // clock enable low: outputs hold however the inputs move
        chk_en <= 1'b0;
        clk_en <= 1'b0;
        @(posedge clk);
        {s_din, s_out, s_oe} = {din, pout, poe};
        for (i = 0; i < 8; i = i + 1) begin
            q = $urandom;
            {dout, oe} <= q[15:0];
            {in_clk, out_clk, io_ce, freeze} <= q[19:16];
            @(posedge clk);
        end
        cmp("ce_din", s_din, din);
        cmp("ce_out", s_out, pout);
        cmp("ce_oe", s_oe, poe);
        // supplies fail: every pin falls back to the released state
        clk_en <= 1'b1;
        supply <= 1'b0;
        repeat (3) @(posedge clk);
        cmp("drop_oe", 8'h00, poe);
        cmp("drop_pull", 8'hff, pull);
        cmp("drop_din", 8'h00, din);
        end_of_test;
    end
endmodule // test_programmable_io_cell
